// [cel_defs.vh]
// Constants for the controller error logger
`ifndef CEL_DEFS_VH
`define CEL_DEFS_VH
// Number of cause bits
`define CEL_NCAUSE 16
// Severity codes
`define CEL_SEV_NONE 2'h0
`define CEL_SEV_ADV 2'h1
`define CEL_SEV_SOFT 2'h2
`define CEL_SEV_HARD 2'h3
// Information register layout
`define CEL_INFO_W 12
`define CEL_INFO_SEV_LO 0
`define CEL_INFO_NUM_LO 2
`define CEL_INFO_M 7
`define CEL_INFO_O 8
`define CEL_INFO_S 9
`define CEL_INFO_G 10
`define CEL_INFO_RSV 11
// Error source codes
`define CEL_SRC_XB0_IN 4'h0
`define CEL_SRC_XB1_IN 4'h1
`define CEL_SRC_XB0_OUT 4'h2
`define CEL_SRC_XB1_OUT 4'h3
`define CEL_SRC_BUS_IN 4'h4
`define CEL_SRC_REGS 4'h5
`define CEL_SRC_HARD 4'h9
// Response word fields, bit numbers counted from lsb
`define CEL_RW_R0 30
`define CEL_RW_TYPE_LO 24
`define CEL_RW_TAG_LO 18
`define CEL_RW_CHIP_LO 15
`define CEL_RW_BOARD_LO 12
`define CEL_RW_CODE_LO 7
`define CEL_RW_NODE_LO 0
`define CEL_LOG_EN_LO 44
`define CEL_LOG_SRC_LO 32
`endif

// [cel_sev_pick.v]
// Priority picker: highest severity cause and its number
`timescale 1ns/1ns
`include "cel_defs.vh"
module cel_sev_pick (
  // Cause events and configuration
  input wire [15:0] hit,
  input wire [31:0] cfg,
  // Result
  output reg [1:0] sev,
  output reg [4:0] num
);
  integer i;
  always @* begin
    sev = `CEL_SEV_NONE;
    num = 5'h00;
    for (i = 0; i < `CEL_NCAUSE; i = i + 1) begin
      // Lowest numbered cause wins among equals
      if (hit[i] && cfg[2*i +: 2] > sev) begin
        sev = cfg[2*i +: 2];
        num = i[4:0];
      end
    end
  end
endmodule // cel_sev_pick

// [cel_resp_word.v]
// Builds the 64-bit error response information word
`timescale 1ns/1ns
`include "cel_defs.vh"
module cel_resp_word (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Field sources
  input wire [3:0] src,
  input wire reply_type_zero,
  input wire [5:0] xbar_type,
  input wire [5:0] txn_tag,
  input wire [2:0] chip_type,
  input wire [2:0] chip_inst,
  input wire [4:0] err_code,
  input wire [6:0] node_num,
  input wire [31:0] internal_info,
  input wire [3:0] cpu_enables,
  input wire hard_directed,
  // Word out, bit 63 is field bit 0
  output reg [63:0] word
);
  reg [31:0] info;
  always @* begin
    info = 32'h00000000;
    if (src == `CEL_SRC_XB0_IN || src == `CEL_SRC_XB1_IN) begin
      info[`CEL_RW_R0] = reply_type_zero;
      info[`CEL_RW_TYPE_LO +: 6] = xbar_type;
      info[`CEL_RW_TAG_LO +: 6] = txn_tag;
      info[`CEL_RW_CHIP_LO +: 3] = chip_type;
      info[`CEL_RW_BOARD_LO +: 3] = chip_inst;
      info[`CEL_RW_CODE_LO +: 5] = err_code;
      info[`CEL_RW_NODE_LO +: 7] = node_num;
    end else begin
      info = internal_info;
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      word <= 64'h0000000000000000;
    end else if (hard_directed) begin
      word <= 64'h0000000000000000;
      word[`CEL_LOG_EN_LO +: 4] <= cpu_enables;
      word[`CEL_LOG_SRC_LO +: 4] <= `CEL_SRC_HARD;
    end else begin
      word <= {32'h00000000, src, 28'h0000000} | {32'h00000000, info};
      word[63:32] <= 32'h00000000;
      word[`CEL_LOG_SRC_LO +: 4] <= src;
      word[31:0] <= info;
    end
  end
endmodule // cel_resp_word

// [controller_error_logger.v]
// Per-controller error logger
// Function
// - Bit 33 flags type-zero reply
// - Bits 34-39 type, 40-45 tag
// - Bits 46-48 chip, 49-51 instance
// - Bits 52-56 code, 57-63 node
// - Internal sources carry own 32-bit info
// - Hard log keeps only first hard error
// - Hard error directs check to enabled processors
// - One sticky cause bit per circumstance
// - Hard error masks all other logging
// - Cause, info and address log survive reset after hard error; hard log is cleared
// - Address updates only with information
// - Severity none<advisory<soft<hard
// - Error number kept for advisory, soft
// - Lower or equal severity sets multiple
// - Higher severity overwrites, sets overwritten
// - Peer hard input during log sets simultaneous
// - Two config bits per cause
// - Disabled cause ignored where completion possible
// - Freeze option holds hard error registers
// - Registers load/store and scan accessible
// - Hard error freezes cause, info, address and hard log except the peer flag; response word still loads
`timescale 1ns/1ns
`include "cel_defs.vh"
module controller_error_logger (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Error detection
  input wire [15:0] err_event,
  input wire [39:0] err_addr,
  input wire [15:0] cause_fatal,
  // Shared hard-error signal
  input wire peer_hard_in,
  output wire hard_out,
  // Configuration
  input wire [31:0] err_cfg,
  input wire stop_on_hard,
  input wire [3:0] cpu_enables,
  // Software and scan access
  input wire cause_wr,
  input wire [15:0] cause_wdata,
  input wire info_wr,
  input wire [11:0] info_wdata,
  input wire addr_wr,
  input wire [39:0] addr_wdata,
  input wire scan_wr,
  // Response word sources
  input wire [3:0] resp_src,
  input wire reply_type_zero,
  input wire [5:0] xbar_type,
  input wire [5:0] txn_tag,
  input wire [2:0] chip_type,
  input wire [2:0] chip_inst,
  input wire [4:0] err_code,
  input wire [6:0] node_num,
  input wire [31:0] internal_info,
  // State out
  output reg [15:0] err_cause,
  output reg [11:0] err_info,
  output reg [39:0] err_addr_log,
  output reg [15:0] hard_first,
  output reg scan_hold,
  output wire [15:0] cause_ignore,
  output wire [63:0] resp_word,
  output reg high_priority_check
);
  // ==========================================================
  // Classification
  wire [15:0] hit;
  wire [15:0] hard_hit;
  wire [1:0] new_sev;
  wire [4:0] new_num;
  wire [1:0] cur_sev;
  wire peer_flag;
  wire own_hard;
  wire masked;
  wire frozen;
  wire do_log;
  wire upd_info;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : cls
      // Disabled non-fatal causes are dropped entirely
      assign cause_ignore[g] = (err_cfg[2*g +: 2] == 2'h0)
        && !cause_fatal[g];
      assign hit[g] = err_event[g] && !cause_ignore[g];
      assign hard_hit[g] = hit[g] && (err_cfg[2*g +: 2] == 2'h3);
    end
  endgenerate
  cel_sev_pick u_pick (
    .hit(hit & {16{~cause_ignore[0] | 1'b1}}),
    .cfg(err_cfg),
    .sev(new_sev),
    .num(new_num)
  );
  assign cur_sev = err_info[`CEL_INFO_SEV_LO +: 2];
  assign peer_flag = err_info[`CEL_INFO_G];
  assign own_hard = (cur_sev == `CEL_SEV_HARD);
  // Masked once any hard error is held, own or peer
  assign masked = peer_flag || own_hard;
  assign frozen = stop_on_hard && own_hard;
  assign do_log = |hit && !masked && !frozen;
  assign upd_info = do_log && (new_sev > cur_sev);
  assign hard_out = own_hard || (do_log && new_sev == `CEL_SEV_HARD);
  // ==========================================================
  // Reset preservation
  // Cause, info and address state is kept through reset while a hard error or the peer
  // flag is held; masked comes from the preserved register itself, so an
  // async-cleared copy would wrongly let reset wipe the log.
  // ==========================================================
  // Cause register
  always @(posedge clock) begin
    if (reset && !masked) begin
      err_cause <= 16'h0000;
    end else if (!reset) begin
      if (cause_wr || scan_wr) begin
        // Set wins over clear for concurrent events
        err_cause <= cause_wdata | (do_log ? hit : 16'h0000);
      end else if (do_log) begin
        err_cause <= err_cause | hit;
      end
    end
  end
  // ==========================================================
  // Information and address registers
  always @(posedge clock) begin
    if (reset && !masked) begin
      err_info <= 12'h000;
      err_addr_log <= 40'h0000000000;
    end else if (!reset) begin
      if (info_wr || scan_wr) begin
        err_info <= info_wdata;
        if (peer_hard_in) begin
          err_info[`CEL_INFO_G] <= 1'b1;
        end
      end else begin
        if (peer_hard_in) begin
          err_info[`CEL_INFO_G] <= 1'b1;
        end
        if (upd_info) begin
          err_info[`CEL_INFO_SEV_LO +: 2] <= new_sev;
          err_info[`CEL_INFO_NUM_LO +: 5] <= new_num;
          if (cur_sev != `CEL_SEV_NONE) begin
            err_info[`CEL_INFO_O] <= 1'b1;
          end
        end else if (do_log) begin
          err_info[`CEL_INFO_M] <= 1'b1;
        end
        if (do_log && peer_hard_in) begin
          err_info[`CEL_INFO_S] <= 1'b1;
        end
      end
      if (addr_wr || scan_wr) begin
        err_addr_log <= addr_wdata;
      end else if (upd_info) begin
        err_addr_log <= err_addr;
      end
    end
  end
  // ==========================================================
  // First hard error capture and directed check
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      hard_first <= 16'h0000;
      scan_hold <= 1'b0;
      high_priority_check <= 1'b0;
    end else begin
      // Later hard errors are ignored once one is held
      if (hard_first == 16'h0000 && do_log && (|hard_hit)) begin
        hard_first <= hard_hit;
      end
      scan_hold <= frozen || (stop_on_hard && do_log && (|hard_hit));
      high_priority_check <= do_log && (|hard_hit) && (|cpu_enables);
    end
  end
  cel_resp_word u_word (
    .clock(clock),
    .reset(reset),
    .src(resp_src),
    .reply_type_zero(reply_type_zero),
    .xbar_type(xbar_type),
    .txn_tag(txn_tag),
    .chip_type(chip_type),
    .chip_inst(chip_inst),
    .err_code(err_code),
    .node_num(node_num),
    .internal_info(internal_info),
    .cpu_enables(cpu_enables),
    .hard_directed(do_log && (|hard_hit)),
    .word(resp_word)
  );
endmodule // controller_error_logger

// [cel_peer.sv]
// Peer controller model driving the shared hard-error line
`timescale 1ns/1ns
module cel_peer (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Command and shared line
  input wire want,
  output reg peer_hard
);
  // Level changes only after an edge and is held, as a real peer does
  always @(posedge clock or posedge reset) begin
    if (reset)
      peer_hard <= 1'h0;
    else
      peer_hard <= want;
  end
endmodule // cel_peer

// [cel_check_sva.sv]
// Checker for the controller error logger ports
`timescale 1ns/1ns
module cel_check (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Inputs watched
  input wire [15:0] err_event,
  input wire peer_hard_in,
  input wire cause_wr,
  input wire info_wr,
  input wire addr_wr,
  input wire scan_wr,
  // Outputs watched
  input wire [15:0] cause_ignore,
  input wire [15:0] err_cause,
  input wire [11:0] err_info,
  input wire [39:0] err_addr_log,
  input wire [15:0] hard_first,
  input wire scan_hold,
  input wire hard_out,
  input wire high_priority_check
);
  // ========
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire wr = cause_wr | info_wr | addr_wr | scan_wr;
  wire [15:0] ev = err_event & ~cause_ignore;
  wire lock = err_info[1:0] == 2'h3 || err_info[10];
  a_cause_sticky:
    assert property (!wr |=> &(err_cause | ~$past(err_cause)))
      else $error("cause bit lost");
  a_event_sets_cause:
    assert property (|ev && !lock && !peer_hard_in && !wr && !scan_hold
      |=> &(err_cause | ~$past(ev))) else $error("cause not logged");
  a_hard_masks_log:
    assert property (lock && !wr && !peer_hard_in
      |=> $stable(err_info) && $stable(err_cause)) else $error("logged");
  a_peer_sets_flag:
    assert property (peer_hard_in |=> err_info[10])
      else $error("peer flag missing");
  a_hard_drives_out:
    assert property (err_info[1:0] == 2'h3 |-> hard_out)
      else $error("hard line low");
  a_first_hard_kept:
    assert property (|hard_first |=> $stable(hard_first))
      else $error("first hard changed");
  a_overwrite_higher:
    assert property ((!err_info[8] && !wr ##1 err_info[8])
      |-> err_info[1:0] > $past(err_info[1:0])) else $error("bad overwrite");
  a_multiple_keeps:
    assert property ((!err_info[7] && !err_info[8] && !wr ##1 err_info[7] &&
      !err_info[8]) |-> err_info[6:0] == $past(err_info[6:0]))
      else $error("info lost");
  a_addr_with_info:
    assert property ((!wr ##1 $changed(err_addr_log)) |-> $changed(err_info))
      else $error("address alone");
  a_check_pulse:
    assert property (high_priority_check |=> !high_priority_check)
      else $error("check pulse long");
endmodule // cel_check

// [controller_error_logger_test.sv]
// Testbench for the controller error logger
`timescale 1ns/1ns
module controller_error_logger_test;
  reg clock = 1'h0, reset = 1'h1, want = 1'h0, reply_type_zero = 1'h1;
  reg stop_on_hard = 1'h0, cause_wr = 1'h0, info_wr = 1'h0;
  reg addr_wr = 1'h0, scan_wr = 1'h0;
  reg [15:0] err_event = '0, cause_fatal = '0, cause_wdata = '0;
  reg [39:0] err_addr = '0, addr_wdata = '0;
  reg [31:0] err_cfg = 32'h0000_3188, internal_info = 32'h1357_9bdf;
  reg [3:0] cpu_enables = 4'h5, resp_src = 4'h0;
  reg [5:0] xbar_type = 6'h2d, txn_tag = 6'h13;
  reg [2:0] chip_type = 3'h5, chip_inst = 3'h6;
  reg [4:0] err_code = 5'h15;
  reg [6:0] node_num = 7'h4b;
  reg [11:0] info_wdata = '0;
  wire peer_hard_in, hard_out, scan_hold, high_priority_check;
  wire [15:0] err_cause, hard_first, cause_ignore;
  wire [11:0] err_info;
  wire [39:0] err_addr_log;
  wire [63:0] resp_word;
  integer fails = 0, total_checks = 0;
  cel_peer peer (.clock, .reset, .want, .peer_hard(peer_hard_in));
  controller_error_logger uut (.clock, .reset, .err_event, .err_addr,
    .cause_fatal, .peer_hard_in, .hard_out, .err_cfg, .stop_on_hard,
    .cpu_enables, .cause_wr, .cause_wdata, .info_wr, .info_wdata, .addr_wr,
    .addr_wdata, .scan_wr, .resp_src, .reply_type_zero, .xbar_type, .txn_tag,
    .chip_type, .chip_inst, .err_code, .node_num, .internal_info, .err_cause,
    .err_info, .err_addr_log, .hard_first, .scan_hold, .cause_ignore,
    .resp_word, .high_priority_check);
  initial begin
    forever #50 clock = ~clock;
  end
  // ========
  // Shared tasks
  task chk(input string what, input [63:0] exp, input [63:0] got);
    total_checks = total_checks + 1;
    if (exp !== got) begin
      fails = fails + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task ev(input [15:0] c, input [39:0] a);
    @(posedge clock);
    err_event <= c;
    err_addr <= a;
    @(posedge clock);
    err_event <= '0;
    #1;
  endtask
  task clear_log;
    @(posedge clock);
    cause_wr <= 1'h1;
    info_wr <= 1'h1;
    @(posedge clock);
    cause_wr <= 1'h0;
    info_wr <= 1'h0;
    #1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ========
  // Scenarios
  task t_resp;
    integer i;
    repeat (2) @(posedge clock);
    #1 chk("type zero", reply_type_zero, resp_word[30]);
    chk("type tag", {xbar_type, txn_tag}, resp_word[29:18]);
    chk("chip", {chip_type, chip_inst}, resp_word[17:12]);
    chk("code node", {err_code, node_num}, resp_word[11:0]);
    for (i = 2; i < 6; i = i + 1) begin
      @(posedge clock) resp_src <= i[3:0];
      repeat (2) @(posedge clock);
      #1 chk("internal", internal_info, resp_word[31:0]);
    end
  endtask
  task t_ignore;
    ev(16'h0001, 40'h00_0000_0001);
    chk("ignore", 16'h0001, cause_ignore & 16'h0009);
    chk("disabled cause", 16'h0000, err_cause);
  endtask
  task t_log;
    ev(16'h0008, 40'h12_3456_789a);
    chk("soft info", 12'h00e, err_info);
    chk("addr", 40'h12_3456_789a, err_addr_log);
    ev(16'h0008, 40'h00_0000_0000);
    chk("equal info", 12'h08e, err_info);
    chk("addr held", 40'h12_3456_789a, err_addr_log);
    ev(16'h0010, 40'h00_0000_0000);
    chk("lower info", 12'h08e, err_info);
    ev(16'h0040, 40'h00_0000_0abc);
    chk("hard info", 12'h183, err_info & 12'hf83);
    chk("hard addr", 40'h00_0000_0abc, err_addr_log);
    chk("first hard", 16'h0040, hard_first);
    chk("hard line", 1'h1, hard_out);
    ev(16'h0002, 40'h00_0000_0000);
    chk("masked", 16'h0058, err_cause);
    @(posedge clock) reset <= 1'h1;
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    #1 chk("kept cause", 16'h0058, err_cause);
    chk("kept info", 12'h183, err_info & 12'hf83);
    clear_log;
    chk("cleared", 12'h000, err_info);
  endtask
  task t_peer;
    @(posedge clock) want <= 1'h1;
    repeat (2) @(posedge clock);
    #1 chk("peer flag", 1'h1, err_info[10]);
    ev(16'h0008, 40'h00_0000_0000);
    chk("peer mask", 16'h0000, err_cause);
    @(posedge clock) want <= 1'h0;
    ev(16'h0008, 40'h00_0000_0000);
    chk("flag mask", 16'h0000, err_cause);
    clear_log;
    ev(16'h0008, 40'h00_0000_0000);
    chk("unmasked", 16'h0008, err_cause);
  endtask
  task t_group;
    @(posedge clock) want <= 1'h1;
    @(posedge clock);
    err_event <= 16'h0040;
    stop_on_hard <= 1'h1;
    @(posedge clock);
    err_event <= '0;
    want <= 1'h0;
    #1 chk("group info", 12'h71b, err_info);
    chk("group cause", 16'h0048, err_cause);
    chk("group first", 16'h0040, hard_first);
    chk("directed", 32'h0000_5009, resp_word[63:32]);
    chk("check on", 1'h1, high_priority_check);
    chk("hold on", 1'h1, scan_hold);
    @(posedge clock);
    #1 chk("check off", 1'h0, high_priority_check);
    chk("hold kept", 1'h1, scan_hold);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'h0;
    t_resp;
    t_ignore;
    t_log;
    t_peer;
    t_group;
    finish_test;
  end
endmodule // controller_error_logger_test
bind controller_error_logger cel_check chk (.clock, .reset, .err_event,
  .peer_hard_in, .cause_wr, .info_wr, .addr_wr, .scan_wr, .cause_ignore,
  .err_cause, .err_info, .err_addr_log, .hard_first, .scan_hold, .hard_out,
  .high_priority_check);
